// file: tps_defines.svh
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH

// Register word offsets (byte addresses)
`define TPS_OFF_TSC   8'h00
`define TPS_OFF_CNT   8'h04
`define TPS_OFF_MOD   8'h08
`define TPS_OFF_SC0   8'h0C
`define TPS_OFF_VAL0  8'h10
`define TPS_OFF_SC1   8'h14
`define TPS_OFF_VAL1  8'h18

// Timer status/control bit positions
`define TPS_TOF       7
`define TPS_OVERFLOW_IRQ_ENABLE      6
`define TPS_COUNTER_STOP     5
`define TPS_TRST      4
`define TPS_PS_HI     2

// Channel status/control bit positions
`define TPS_CHF       7
`define TPS_CFG_HI    6

// Reset values and constants
`define TPS_MOD_RST   16'hFFFF
`define TPS_CNT_ZERO  16'h0000
`define TPS_CNT_ONE   16'h0001
`define TPS_PS_OFF    3'h7
`define TPS_PRE_ZERO  6'h00
`define TPS_PRE_ONE   6'h01
`define TPS_DATA_ZERO 32'h0000_0000

`endif

// file: tps_pkg.sv
package tps_pkg;

    typedef struct packed {
        logic irq_en;
        logic mode_b;
        logic mode_a;
        logic els_hi;
        logic els_lo;
        logic tov;
        logic max;
    } tps_cfg_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        step;
        logic        ovf;
    } tps_tick_t;

    typedef enum logic {
        TPS_IDLE = 1'b0,
        TPS_RESP = 1'b1
    } tps_apb_st_t;

endpackage

// file: tps_channel.sv
`timescale 1ns/100ps
`include "tps_defines.svh"
module tps_channel
    import tps_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        enable_in,
    input  wire tps_cfg_t    cfg_in,
    input  wire tps_tick_t   tick_in,
    input  wire logic [15:0] val_in,
    input  wire logic        pin_in,
    output logic             pin_out,
    output logic             pin_oe_out,
    output logic             cmp_out,
    output logic             cap_out
);

    logic pin_q;
    logic max_act;
    logic next_pin_q;
    logic next_max_act;
    logic next_pin_out;
    logic next_pin_oe;
    logic oc;
    logic preset;
    logic pulse;

    always_comb
    begin
        oc           = cfg_in.mode_b | cfg_in.mode_a;
        preset       = ~cfg_in.els_hi & ~cfg_in.els_lo;
        pulse        = ~(cfg_in.els_hi & cfg_in.els_lo);
        next_pin_q   = pin_in;
        cap_out      = enable_in & ~oc & ~preset
                     & ((cfg_in.els_lo & pin_in & ~pin_q)
                     | (cfg_in.els_hi & ~pin_in & pin_q));
        cmp_out      = enable_in & oc & ~preset & tick_in.step
                     & (tick_in.cnt == val_in);
        next_max_act = max_act;
        next_pin_out = pin_out;
        next_pin_oe  = enable_in & oc & ~preset;
        if (!enable_in || preset)
        begin
            next_pin_out = ~cfg_in.mode_a;
            next_max_act = 1'b0;
        end
        else if (oc)
        begin
            if (tick_in.ovf)
            begin
                next_max_act = cfg_in.max & cfg_in.tov;
            end
            if (tick_in.ovf && cfg_in.tov)
            begin
                // Overflow action wins over a coincident compare
                next_pin_out = next_max_act ? pulse : ~pin_out;
            end
            else if (cmp_out && !max_act)
            begin
                case ({cfg_in.els_hi, cfg_in.els_lo})
                    2'h1:    next_pin_out = ~pin_out;
                    2'h2:    next_pin_out = 1'b0;
                    2'h3:    next_pin_out = 1'b1;
                    default: next_pin_out = pin_out;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_q      <= 1'b0;
            max_act    <= 1'b0;
            pin_out    <= 1'b1;
            pin_oe_out <= 1'b0;
        end
        else if (ce_in)
        begin
            pin_q      <= next_pin_q;
            max_act    <= next_max_act;
            pin_out    <= next_pin_out;
            pin_oe_out <= next_pin_oe;
        end
    end

endmodule

// file: tps_top.sv
// Behaviour
// - Buffered bit pairs channels, output on pin 0
// - Channel 0 first; channel 1 write switches
// - At overflow, last written pair becomes active
// - Buffered mode frees channel 1 control, pin
// - Writing active pair takes effect immediately
// - New compare value overwrites at once
// - Toggle-on-overflow clear gives 0% duty
// - Max duty with toggle-on-overflow gives 100%
// - Overflow sets flag; enable gates request
// - Channel events set flag; enable gates request
// - Wait mode: counting continues, registers locked
// - Stop mode halts timer, keeps state
// - Break halts the counter
// - Break protects flags unless clear enabled
// - Flag clears by read then write zero
// - Stop bit holds counter; reset sets it
// - Counter reset bit clears counter, prescaler
// - Stop plus reset leaves counter at zero
// - Prescaler divides bus clock by powers
// - Counter restarts from zero after modulo
// - Edge/level codes pick compare output action
// - Overflow toggle beats coincident compare
// - Max duty change applies next period
`timescale 1ns/100ps
`include "tps_defines.svh"
module tps_top
    import tps_pkg::*;
(
    input  wire logic        CLOCK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        CE_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        WAIT_MODE_IN,
    input  wire logic        STOP_MODE_IN,
    input  wire logic        BREAK_IN,
    input  wire logic        BREAK_CLEAR_EN_IN,
    input  wire logic        CH0_PIN_IN,
    input  wire logic        CH1_PIN_IN,
    output logic             CH0_PIN_OUT,
    output logic             CH0_PIN_OE_OUT,
    output logic             CH1_PIN_OUT,
    output logic             CH1_PIN_OE_OUT,
    output logic             OVF_IRQ_OUT,
    output logic             CH0_IRQ_OUT,
    output logic             CH1_IRQ_OUT,
    output logic             WAKE_OUT
);

    function automatic logic addr_ok(input logic [7:0] a);
        case (a)
            `TPS_OFF_TSC, `TPS_OFF_CNT, `TPS_OFF_MOD, `TPS_OFF_SC0,
            `TPS_OFF_VAL0, `TPS_OFF_SC1, `TPS_OFF_VAL1: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    endfunction

    // Set wins over clear; clear needs the armed read first
    function automatic logic flag_next(input logic f, input logic arm,
                                       input logic set, input logic clr);
        flag_next = set | (f & ~(clr & arm));
    endfunction

    // A new event cancels a half-done clearing sequence
    function automatic logic arm_next(input logic f, input logic arm,
                                      input logic set, input logic rd);
        arm_next = ~set & (arm | (rd & f));
    endfunction

    function automatic logic [5:0] pre_mask(input logic [2:0] code);
        pre_mask = (`TPS_PRE_ONE << code) - `TPS_PRE_ONE;
    endfunction

    // Bus slave state
    tps_apb_st_t st;
    tps_apb_st_t next_st;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [31:0] rdata;
    logic        ok;
    logic        wr;
    logic        rd;
    logic        allow;

    // Counter state
    logic        overflow_flag;
    logic        tof_arm;
    logic        overflow_irq_enable;
    logic        counter_stop;
    logic [2:0]  ps;
    logic [5:0]  presc;
    logic [15:0] cnt;
    logic [15:0] modv;
    logic        next_tof;
    logic        next_tof_arm;
    logic        next_overflow_irq_enable;
    logic        next_counter_stop;
    logic [2:0]  next_ps;
    logic [5:0]  next_presc;
    logic [15:0] next_cnt;
    logic [15:0] next_modv;
    logic        run;
    logic        tick;
    logic        trst;
    logic [15:0] cnt_nx;
    tps_tick_t   tk;

    // Channel state
    tps_cfg_t    cfg [2];
    tps_cfg_t    next_cfg [2];
    logic [1:0]  chf;
    logic [1:0]  arm;
    logic [1:0]  next_chf;
    logic [1:0]  next_arm;
    logic [15:0] val [2];
    logic [15:0] next_val [2];
    logic        last1;
    logic        act1;
    logic        next_last1;
    logic        next_act1;
    logic        buffered;
    logic [15:0] val0_eff;
    logic [1:0]  wr_sc;
    logic [1:0]  wr_val;
    logic [1:0]  rd_sc;
    logic [1:0]  cmp;
    logic [1:0]  cap;
    logic [3:0]  next_irq;

    // Bus slave: access completes one cycle after the access phase opens
    always_comb
    begin
        allow    = ~BREAK_IN | BREAK_CLEAR_EN_IN;
        buffered = cfg[0].mode_b;
        case (PADDR_IN)
            `TPS_OFF_TSC:  rdata = {24'h00_0000, overflow_flag, overflow_irq_enable, counter_stop, 2'h0, ps};
            `TPS_OFF_CNT:  rdata = {16'h0000, cnt};
            `TPS_OFF_MOD:  rdata = {16'h0000, modv};
            `TPS_OFF_SC0:  rdata = {24'h00_0000, chf[0], cfg[0]};
            `TPS_OFF_VAL0: rdata = {16'h0000, val[0]};
            `TPS_OFF_SC1:  rdata = buffered ? `TPS_DATA_ZERO
                                            : {24'h00_0000, chf[1], cfg[1]};
            `TPS_OFF_VAL1: rdata = {16'h0000, val[1]};
            default:       rdata = `TPS_DATA_ZERO;
        endcase
        next_st      = st;
        next_prdata  = PRDATA_OUT;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        case (st)
            TPS_IDLE:
            begin
                if (PSEL_IN && PENABLE_IN)
                begin
                    next_st      = TPS_RESP;
                    next_pready  = 1'b1;
                    next_pslverr = WAIT_MODE_IN | ~addr_ok(PADDR_IN);
                    next_prdata  = (WAIT_MODE_IN || PWRITE_IN) ? `TPS_DATA_ZERO : rdata;
                end
            end
            TPS_RESP:
            begin
                next_st = TPS_IDLE;
            end
            default:
            begin
                next_st = TPS_IDLE;
            end
        endcase
        ok        = (st == TPS_RESP) & PSEL_IN & PENABLE_IN
                  & ~WAIT_MODE_IN & addr_ok(PADDR_IN);
        wr        = ok & PWRITE_IN;
        rd        = ok & ~PWRITE_IN;
        wr_sc[0]  = wr & (PADDR_IN == `TPS_OFF_SC0);
        wr_sc[1]  = wr & (PADDR_IN == `TPS_OFF_SC1) & ~buffered;
        rd_sc[0]  = rd & (PADDR_IN == `TPS_OFF_SC0);
        rd_sc[1]  = rd & (PADDR_IN == `TPS_OFF_SC1) & ~buffered;
        wr_val[0] = wr & (PADDR_IN == `TPS_OFF_VAL0);
        wr_val[1] = wr & (PADDR_IN == `TPS_OFF_VAL1);
    end

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            st          <= TPS_IDLE;
            PRDATA_OUT  <= `TPS_DATA_ZERO;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
        else if (CE_IN)
        begin
            st          <= next_st;
            PRDATA_OUT  <= next_prdata;
            PREADY_OUT  <= next_pready;
            PSLVERR_OUT <= next_pslverr;
        end
    end

    // Prescaler, counter and overflow flag
    always_comb
    begin
        trst   = wr & (PADDR_IN == `TPS_OFF_TSC) & PWDATA_IN[`TPS_TRST];
        run    = ~counter_stop & ~STOP_MODE_IN & ~BREAK_IN;
        tick   = run & (ps != `TPS_PS_OFF)
               & ((presc & pre_mask(ps)) == pre_mask(ps));
        cnt_nx = (cnt == modv) ? `TPS_CNT_ZERO : cnt + `TPS_CNT_ONE;
        tk.cnt  = cnt_nx;
        tk.step = tick & ~trst;
        tk.ovf  = tick & ~trst & (cnt_nx == modv);
        next_presc = run ? presc + `TPS_PRE_ONE : presc;
        next_cnt   = tk.step ? cnt_nx : cnt;
        next_overflow_irq_enable  = overflow_irq_enable;
        next_counter_stop = counter_stop;
        next_ps    = ps;
        next_modv  = modv;
        if (trst)
        begin
            // Only counter and prescaler; stop bit is left as written
            next_presc = `TPS_PRE_ZERO;
            next_cnt   = `TPS_CNT_ZERO;
        end
        if (wr && PADDR_IN == `TPS_OFF_TSC)
        begin
            next_overflow_irq_enable  = PWDATA_IN[`TPS_OVERFLOW_IRQ_ENABLE];
            next_counter_stop = PWDATA_IN[`TPS_COUNTER_STOP];
            next_ps    = PWDATA_IN[`TPS_PS_HI:0];
        end
        if (wr && PADDR_IN == `TPS_OFF_MOD)
        begin
            next_modv = PWDATA_IN[15:0];
        end
        next_tof     = flag_next(overflow_flag, tof_arm, tk.ovf,
                                 wr & (PADDR_IN == `TPS_OFF_TSC)
                                 & ~PWDATA_IN[`TPS_TOF] & allow);
        next_tof_arm = arm_next(overflow_flag, tof_arm, tk.ovf,
                                rd & (PADDR_IN == `TPS_OFF_TSC) & allow);
    end

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            overflow_flag     <= 1'b0;
            tof_arm <= 1'b0;
            overflow_irq_enable    <= 1'b0;
            counter_stop   <= 1'b1;
            ps      <= 3'h0;
            presc   <= `TPS_PRE_ZERO;
            cnt     <= `TPS_CNT_ZERO;
            modv    <= `TPS_MOD_RST;
        end
        else if (CE_IN)
        begin
            overflow_flag     <= next_tof;
            tof_arm <= next_tof_arm;
            overflow_irq_enable    <= next_overflow_irq_enable;
            counter_stop   <= next_counter_stop;
            ps      <= next_ps;
            presc   <= next_presc;
            cnt     <= next_cnt;
            modv    <= next_modv;
        end
    end

    // Channel configuration, values, flags and buffered pairing
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            next_cfg[i] = cfg[i];
            next_val[i] = val[i];
            if (wr_sc[i])
            begin
                next_cfg[i] = tps_cfg_t'(PWDATA_IN[`TPS_CFG_HI:0]);
            end
            if (cap[i])
            begin
                next_val[i] = cnt;
            end
            if (wr_val[i])
            begin
                next_val[i] = PWDATA_IN[15:0];
            end
            next_chf[i] = flag_next(chf[i], arm[i], cmp[i] | cap[i],
                                    wr_sc[i] & ~PWDATA_IN[`TPS_CHF] & allow);
            next_arm[i] = arm_next(chf[i], arm[i], cmp[i] | cap[i],
                                   rd_sc[i] & allow);
        end
        // Only channel 0 carries the buffered bit
        next_cfg[1].mode_b = 1'b0;
        next_last1 = 1'b0;
        next_act1  = 1'b0;
        if (buffered)
        begin
            next_last1 = wr_val[1] ? 1'b1 : (wr_val[0] ? 1'b0 : last1);
            next_act1  = tk.ovf ? next_last1 : act1;
        end
        val0_eff    = (buffered && act1) ? val[1] : val[0];
        next_irq[0] = next_tof & next_overflow_irq_enable;
        next_irq[1] = next_chf[0] & next_cfg[0].irq_en;
        next_irq[2] = next_chf[1] & next_cfg[1].irq_en;
        next_irq[3] = WAIT_MODE_IN & (|next_irq[2:0]);
    end

    always_ff @(posedge CLOCK_IN or posedge SYS_RST_IN)
    begin
        if (SYS_RST_IN)
        begin
            cfg[0]      <= '0;
            cfg[1]      <= '0;
            val[0]      <= `TPS_CNT_ZERO;
            val[1]      <= `TPS_CNT_ZERO;
            chf         <= 2'h0;
            arm         <= 2'h0;
            last1       <= 1'b0;
            act1        <= 1'b0;
            OVF_IRQ_OUT <= 1'b0;
            CH0_IRQ_OUT <= 1'b0;
            CH1_IRQ_OUT <= 1'b0;
            WAKE_OUT    <= 1'b0;
        end
        else if (CE_IN)
        begin
            cfg[0]      <= next_cfg[0];
            cfg[1]      <= next_cfg[1];
            val[0]      <= next_val[0];
            val[1]      <= next_val[1];
            chf         <= next_chf;
            arm         <= next_arm;
            last1       <= next_last1;
            act1        <= next_act1;
            OVF_IRQ_OUT <= next_irq[0];
            CH0_IRQ_OUT <= next_irq[1];
            CH1_IRQ_OUT <= next_irq[2];
            WAKE_OUT    <= next_irq[3];
        end
    end

    // Channel 0 drives the buffered pair output
    tps_channel u_ch0
    (
        .clk_in     (CLOCK_IN),
        .rst_in     (SYS_RST_IN),
        .ce_in      (CE_IN),
        .enable_in  (1'b1),
        .cfg_in     (cfg[0]),
        .tick_in    (tk),
        .val_in     (val0_eff),
        .pin_in     (CH0_PIN_IN),
        .pin_out    (CH0_PIN_OUT),
        .pin_oe_out (CH0_PIN_OE_OUT),
        .cmp_out    (cmp[0]),
        .cap_out    (cap[0])
    );

    // Channel 1 is switched off while paired
    tps_channel u_ch1
    (
        .clk_in     (CLOCK_IN),
        .rst_in     (SYS_RST_IN),
        .ce_in      (CE_IN),
        .enable_in  (~buffered),
        .cfg_in     (cfg[1]),
        .tick_in    (tk),
        .val_in     (val[1]),
        .pin_in     (CH1_PIN_IN),
        .pin_out    (CH1_PIN_OUT),
        .pin_oe_out (CH1_PIN_OE_OUT),
        .cmp_out    (cmp[1]),
        .cap_out    (cap[1])
    );

endmodule

// file: tps_asserts.sv
`timescale 1ns/100ps
`include "tps_defines.svh"
module tps_asserts
    import tps_pkg::*;
(
    input  wire logic        CLOCK_IN,
    input  wire logic        SYS_RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [31:0] PRDATA_OUT,
    input  wire logic        PREADY_OUT,
    input  wire logic        PSLVERR_OUT,
    input  wire logic        WAIT_MODE_IN,
    input  wire logic        STOP_MODE_IN,
    input  wire logic        BREAK_IN,
    input  wire logic        CH0_PIN_OUT,
    input  wire logic        CH1_PIN_OUT,
    input  wire logic        CH1_PIN_OE_OUT,
    input  wire logic        OVF_IRQ_OUT,
    input  wire logic        CH0_IRQ_OUT,
    input  wire logic        CH1_IRQ_OUT,
    input  wire logic        WAKE_OUT
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (SYS_RST_IN);

    // Accepted write to one register
    sequence s_wr(logic [7:0] a);
        PREADY_OUT && PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == a
            && !PSLVERR_OUT && !WAIT_MODE_IN;
    endsequence
    // No transfer finished in the last two cycles
    sequence s_quiet;
        !$past(PREADY_OUT) && !$past(PREADY_OUT, 2);
    endsequence

    a_wake_gate: assert property (
        WAKE_OUT |-> $past(WAIT_MODE_IN) && (OVF_IRQ_OUT || CH0_IRQ_OUT || CH1_IRQ_OUT))
        else $error("wake without wait mode and request");
    a_wait_refuse: assert property (
        PREADY_OUT && $past(WAIT_MODE_IN) |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
        else $error("access in wait mode not refused");
    a_trst_reads0: assert property (
        PREADY_OUT && !PWRITE_IN && PADDR_IN == `TPS_OFF_TSC && !PSLVERR_OUT
        |-> PRDATA_OUT[31:8] == 24'h0 && PRDATA_OUT[4:3] == 2'h0)
        else $error("status read shows reset or unused bits");
    a_ovf_irq_off: assert property (
        s_wr(`TPS_OFF_TSC) ##0 !PWDATA_IN[6] |=> !OVF_IRQ_OUT)
        else $error("overflow request with enable clear");
    a_ch0_irq_off: assert property (
        s_wr(`TPS_OFF_SC0) ##0 !PWDATA_IN[6] |=> !CH0_IRQ_OUT)
        else $error("channel 0 request with enable clear");
    a_ch1_release: assert property (
        s_wr(`TPS_OFF_SC0) ##0 PWDATA_IN[5] |-> ##2 !CH1_PIN_OE_OUT [*3])
        else $error("channel 1 pin driven in buffered mode");
    a_stop_hold: assert property (
        STOP_MODE_IN && $past(STOP_MODE_IN) && $past(STOP_MODE_IN, 2) ##0 s_quiet
        |-> $stable(CH0_PIN_OUT) && $stable(CH1_PIN_OUT))
        else $error("pin changed in stop mode");
    a_break_hold: assert property (
        BREAK_IN && $past(BREAK_IN) && $past(BREAK_IN, 2) ##0 s_quiet
        |-> $stable(CH0_PIN_OUT) && $stable(CH1_PIN_OUT))
        else $error("pin changed during break");
    a_addr_refuse: assert property (
        PREADY_OUT && PSEL_IN && PADDR_IN > `TPS_OFF_VAL1 |-> PSLVERR_OUT)
        else $error("unmapped access not refused");
endmodule

bind tps_top tps_asserts chk_u (.CLOCK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN,
    .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .WAIT_MODE_IN,
    .STOP_MODE_IN, .BREAK_IN, .CH0_PIN_OUT, .CH1_PIN_OUT, .CH1_PIN_OE_OUT, .OVF_IRQ_OUT,
    .CH0_IRQ_OUT, .CH1_IRQ_OUT, .WAKE_OUT);

// file: tps_pin_model.sv
`timescale 1ns/100ps
module tps_pin_model
(
    input  wire logic pin_out_in,
    input  wire logic pin_oe_in,
    input  wire logic ext_in,
    output logic      pin_level_out
);
    // Outside logic drives only while the timer has released the pin
    assign pin_level_out = pin_oe_in ? pin_out_in : ext_in;
endmodule

// file: tb_top.sv
`timescale 1ns/100ps
`include "tps_defines.svh"
module tb_top
    import tps_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, brk, brk_clr, wait_m, stop_m, ce;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat, v;
    logic [31:0] seed = 32'h0467;
    logic        pready, pslverr, rerr, p0o, p0e, p1o, p1e, p0i, p1i;
    logic        ovf_irq, ch0_irq, ch1_irq, wake;
    int          n_errors = 0, tests_run = 0, cyc = 0, h;

    tps_top dut_u (.CLOCK_IN(clk), .SYS_RST_IN(rst), .CE_IN(ce), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .WAIT_MODE_IN(wait_m), .STOP_MODE_IN(stop_m), .BREAK_IN(brk),
        .BREAK_CLEAR_EN_IN(brk_clr), .CH0_PIN_IN(p0i), .CH1_PIN_IN(p1i),
        .CH0_PIN_OUT(p0o), .CH0_PIN_OE_OUT(p0e), .CH1_PIN_OUT(p1o), .CH1_PIN_OE_OUT(p1e),
        .OVF_IRQ_OUT(ovf_irq), .CH0_IRQ_OUT(ch0_irq), .CH1_IRQ_OUT(ch1_irq), .WAKE_OUT(wake));
    tps_pin_model pin0_u (.pin_out_in(p0o), .pin_oe_in(p0e), .ext_in(cyc[3]),
        .pin_level_out(p0i));
    tps_pin_model pin1_u (.pin_out_in(p1o), .pin_oe_in(p1e), .ext_in(cyc[4]),
        .pin_level_out(p1i));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function logic [31:0] near(input logic [31:0] s, input int e, input int t);
        return {31'h0, (s + t >= e) && (s <= e + t)};
    endfunction

    task end_of_test();
        if (n_errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task pwm(input logic [7:0] sc, input logic [15:0] val);
        apb(1, `TPS_OFF_TSC, 32'h30);
        apb(1, `TPS_OFF_VAL0, {16'h0, val});
        apb(1, `TPS_OFF_SC0, {24'h0, sc});
        apb(1, `TPS_OFF_TSC, 32'h0);
    endtask

    // High cycles over four periods after settling
    task duty(input int e);
        h = 0;
        repeat (250) @(posedge clk);
        repeat (400)
        begin
            @(posedge clk);
            h += (p0o === 1'b1);
        end
        chk("duty", near(h, e, 8), 32'h1);
    endtask

    task cnt_frozen(input string nm);
        apb(0, `TPS_OFF_CNT, 32'h0);
        v = rdat;
        repeat (30) @(posedge clk);
        apb(0, `TPS_OFF_CNT, 32'h0);
        chk(nm, rdat, v);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    initial
    begin
        {psel, penable, pwrite, brk, brk_clr, wait_m, stop_m} = 7'h0;
        ce = 1'b1;
        paddr = 8'h0;
        pwdata = 32'h0;
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(0, `TPS_OFF_TSC, 32'h0);
        chk("tsc_rst", rdat, 32'h20);
        apb(0, `TPS_OFF_MOD, 32'h0);
        chk("mod_rst", rdat, 32'hFFFF);
        apb(0, 8'h1C, 32'h0);
        chk("unmapped", {rerr, rdat[30:0]}, 32'h8000_0000);
        v = rnd() | 32'h8000;
        apb(1, `TPS_OFF_MOD, {16'h0, v[15:0]});
        for (int ps = 0; ps < 8; ps++)
        begin
            apb(1, `TPS_OFF_TSC, 32'h30);
            apb(1, `TPS_OFF_TSC, 32'(ps));
            // Frozen cycles must not count
            ce <= 1'b0;
            repeat (100) @(posedge clk);
            ce <= 1'b1;
            repeat (256) @(posedge clk);
            apb(1, `TPS_OFF_TSC, 32'h20 | 32'(ps));
            apb(0, `TPS_OFF_CNT, 32'h0);
            chk("prescale", near(rdat, ps == 7 ? 0 : 259 >> ps, 3), 32'h1);
            cnt_frozen("stop_hold");
        end
        apb(1, `TPS_OFF_TSC, 32'h30);
        apb(0, `TPS_OFF_CNT, 32'h0);
        chk("stop_rst", rdat, 32'h0);
        apb(0, `TPS_OFF_TSC, 32'h0);
        chk("trst_rd", rdat, 32'h20);
        apb(1, `TPS_OFF_MOD, 32'h14);
        apb(1, `TPS_OFF_TSC, 32'h40);
        repeat (30) @(posedge clk);
        chk("ovf_irq", 32'(ovf_irq), 32'h1);
        apb(0, `TPS_OFF_CNT, 32'h0);
        chk("cnt_wrap", 32'(rdat <= 32'h14), 32'h1);
        apb(0, `TPS_OFF_TSC, 32'h0);
        chk("tsc_flag", rdat, 32'hC0);
        repeat (30) @(posedge clk);
        apb(1, `TPS_OFF_TSC, 32'h40);
        @(posedge clk);
        chk("clr_cancel", 32'(ovf_irq), 32'h1);
        brk <= 1'b1;
        cnt_frozen("brk_hold");
        apb(0, `TPS_OFF_TSC, 32'h0);
        apb(1, `TPS_OFF_TSC, 32'h40);
        @(posedge clk);
        chk("brk_keep", 32'(ovf_irq), 32'h1);
        brk_clr <= 1'b1;
        apb(0, `TPS_OFF_TSC, 32'h0);
        apb(1, `TPS_OFF_TSC, 32'h60);
        @(posedge clk);
        chk("brk_clear", 32'(ovf_irq), 32'h0);
        brk <= 1'b0;
        brk_clr <= 1'b0;
        apb(0, `TPS_OFF_TSC, 32'h0);
        chk("clr_stays", rdat, 32'h60);
        apb(1, `TPS_OFF_TSC, 32'h40);
        wait_m <= 1'b1;
        repeat (30) @(posedge clk);
        chk("wake", 32'(wake), 32'h1);
        apb(0, `TPS_OFF_TSC, 32'h0);
        chk("wait_rd", {rerr, rdat[30:0]}, 32'h8000_0000);
        apb(1, `TPS_OFF_TSC, 32'h20);
        wait_m <= 1'b0;
        apb(0, `TPS_OFF_CNT, 32'h0);
        v = rdat;
        repeat (10) @(posedge clk);
        apb(0, `TPS_OFF_CNT, 32'h0);
        chk("wait_run", 32'(rdat != v), 32'h1);
        stop_m <= 1'b1;
        cnt_frozen("stop_mode");
        stop_m <= 1'b0;
        apb(1, `TPS_OFF_MOD, 32'h63);
        v = 32'hA + rnd() % 80;
        pwm(8'h5A, v[15:0]);
        duty(4 * (v + 1));
        chk("ch0_irq", 32'(ch0_irq), 32'h1);
        chk("ch0_oe", 32'(p0e), 32'h1);
        pwm(8'h1E, v[15:0]);
        duty(4 * (99 - v));
        pwm(8'h18, v[15:0]);
        duty(0);
        pwm(8'h1B, v[15:0]);
        duty(400);
        pwm(8'h10, v[15:0]);
        repeat (3) @(posedge clk);
        chk("preset", {30'h0, p0e, p0o}, 32'h0);
        apb(1, `TPS_OFF_SC1, 32'h44);
        repeat (40) @(posedge clk);
        chk("ch1_cap", 32'(ch1_irq), 32'h1);
        apb(1, `TPS_OFF_SC1, 32'h1A);
        repeat (2) @(posedge clk);
        chk("ch1_drive", 32'(p1e), 32'h1);
        pwm(8'h2A, 16'h1E);
        duty(124);
        chk("ch1_oe", 32'(p1e), 32'h0);
        apb(0, `TPS_OFF_SC1, 32'h0);
        chk("sc1_hide", rdat, 32'h0);
        apb(1, `TPS_OFF_VAL1, 32'h46);
        duty(284);
        apb(1, `TPS_OFF_VAL0, 32'h32);
        duty(204);
        end_of_test();
    end
endmodule
